//--- logic/emc_pkg.sv
package emc_pkg;
  localparam int          ADDR_W            = 7;
  localparam int          DATA_W            = 16;
  localparam logic [6:0]  ADDR_MODE_ONE     = 7'h0B;
  localparam logic [6:0]  ADDR_MODE_TWO     = 7'h0C;
  localparam logic [6:0]  ADDR_PO2_NUM      = 7'h29;
  localparam logic [6:0]  ADDR_PO2_DEN      = 7'h2A;
  localparam logic [6:0]  ADDR_ZX_CTRL      = 7'h2B;
  localparam logic [6:0]  ADDR_RSVD_A       = 7'h3B;
  localparam logic [6:0]  ADDR_RSVD_B       = 7'h3C;
  localparam logic [6:0]  ADDR_CAL_MODE     = 7'h3D;
  localparam logic [6:0]  ADDR_RSVD_C       = 7'h3E;
  localparam logic [6:0]  ADDR_RSVD_D       = 7'h3F;
  localparam logic [7:0]  RST_MODE_ONE      = 8'h06;
  localparam logic [7:0]  RST_MODE_TWO      = 8'h40;
  localparam logic [15:0] RST_PO2_NUM       = 16'h0000;
  localparam logic [15:0] RST_PO2_DEN       = 16'h003F;
  localparam logic [7:0]  RST_ZX_CTRL       = 8'h00;
  localparam logic [7:0]  RST_RSVD_A        = 8'h00;
  localparam logic [15:0] RST_RSVD_B        = 16'h0300;
  localparam logic [7:0]  RST_CAL_MODE      = 8'h00;
  localparam logic [7:0]  RST_RSVD_C        = 8'h00;
  localparam logic [7:0]  RST_RSVD_D        = 8'h00;
  localparam int          BIT_SOFT_RESET    = 7;
  localparam int          BIT_ZX_FILT_OFF   = 6;
  localparam int          BIT_INTEGRATOR    = 5;
  localparam int          BIT_SWAP          = 4;
  localparam int          BIT_ADC_PD        = 3;
  localparam int          BIT_PO2_OFF       = 2;
  localparam int          BIT_PO1_OFF       = 1;
  localparam int          BIT_HPF_OFF       = 0;
  localparam int          FLD_PO2_SRC_LO    = 6;
  localparam int          FLD_PO1_SRC_LO    = 4;
  localparam int          BIT_APP_RMS       = 3;
  localparam int          BIT_RMS_ON_ZX     = 2;
  localparam int          BIT_LINE_PERIOD_RESULT      = 1;
  localparam int          BIT_WAVE_ON       = 0;
  typedef enum logic [1:0] {
    EMC_SRC_ACTIVE,
    EMC_SRC_REACTIVE,
    EMC_SRC_APPARENT,
    EMC_SRC_IRMS
  } emc_source_t;
endpackage

//--- logic/emc_mode_regs.sv
`timescale 1ns/1ps
// How it works
// - Soft reset returns measurement registers to defaults
// - Bit six bypasses zero-crossing low-pass filter
// - Bit five inserts integrator in current path
// - Bit four swaps first and second ADC
// - Bit three powers down both ADCs
// - Bits two, one disable outputs; reset one
// - Bit zero bypasses both high-pass filters
// - Second source field: active, reactive, apparent/rms
// - First source field, same encoding, reset 00
// - Bit three picks VA or current rms
// - Bit two updates rms on voltage crossings
// - Bit one picks period or frequency result
// - Bit zero enables waveform sampling mode
// - Sixteen-bit numerator and denominator, defaults zero, 3F
// - Eight-bit zero-crossing output control at 2B
// - Eight-bit calibration mode register at 3D
module emc_mode_regs
  import emc_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [emc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [emc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [emc_pkg::DATA_W-1:0] reg_rdata,
  output logic                           meas_soft_reset,
  output logic                           zero_cross_filter_off,
  output logic                           integrator_on,
  output logic                           channel_swap,
  output logic                           adc_power_down,
  output logic                           pulse_out_two_off,
  output logic                           pulse_out_one_off,
  output logic                           highpass_off,
  output emc_pkg::emc_source_t           pulse_out_two_source,
  output emc_pkg::emc_source_t           pulse_out_one_source,
  output logic                           rms_update_on_crossing,
  output logic                           period_or_frequency_choice,
  output logic                           waveform_sampling_on,
  output logic      [15:0]               pulse_out_two_num,
  output logic      [15:0]               pulse_out_two_den,
  output logic      [7:0]                zero_cross_out_en,
  output logic      [7:0]                calibration_mode_sel,
  output logic      [15:0]               reserved_b_val
);
  import emc_pkg::*;

  logic [7:0]  mode_one_reg;
  logic [7:0]  mode_two_reg;
  logic [15:0] po2_num_reg;
  logic [15:0] po2_den_reg;
  logic [7:0]  zx_ctrl_reg;
  logic [7:0]  rsvd_a_reg;
  logic [15:0] rsvd_b_reg;
  logic [7:0]  cal_mode_reg;
  logic [7:0]  rsvd_c_reg;
  logic [7:0]  rsvd_d_reg;
  logic        soft_reset_bit_reg;
  logic [15:0] rdata_next;
  logic        soft_reset_bit_next;
  emc_source_t po1_next;
  emc_source_t po2_next;

  // A write of one to the reset bit is a request, not stored state
  assign soft_reset_bit_next = reg_wr && (reg_addr == ADDR_MODE_ONE) && reg_wdata[BIT_SOFT_RESET];

  // Soft reset takes one cycle; the write that asked for it is dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_bit_reg <= 1'b0;
    end else begin
      soft_reset_bit_reg <= soft_reset_bit_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_one_reg <= RST_MODE_ONE;
      mode_two_reg <= RST_MODE_TWO;
      po2_num_reg  <= RST_PO2_NUM;
      po2_den_reg  <= RST_PO2_DEN;
      zx_ctrl_reg  <= RST_ZX_CTRL;
      rsvd_a_reg   <= RST_RSVD_A;
      rsvd_b_reg   <= RST_RSVD_B;
      cal_mode_reg <= RST_CAL_MODE;
      rsvd_c_reg   <= RST_RSVD_C;
      rsvd_d_reg   <= RST_RSVD_D;
    end else if (soft_reset_bit_next) begin
      mode_one_reg <= RST_MODE_ONE;
      mode_two_reg <= RST_MODE_TWO;
      po2_num_reg  <= RST_PO2_NUM;
      po2_den_reg  <= RST_PO2_DEN;
      zx_ctrl_reg  <= RST_ZX_CTRL;
      rsvd_a_reg   <= RST_RSVD_A;
      rsvd_b_reg   <= RST_RSVD_B;
      cal_mode_reg <= RST_CAL_MODE;
      rsvd_c_reg   <= RST_RSVD_C;
      rsvd_d_reg   <= RST_RSVD_D;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE_ONE: begin
          mode_one_reg <= {1'b0, reg_wdata[6:0]};
        end
        ADDR_MODE_TWO: begin
          mode_two_reg <= reg_wdata[7:0];
        end
        ADDR_PO2_NUM: begin
          po2_num_reg <= reg_wdata;
        end
        ADDR_PO2_DEN: begin
          po2_den_reg <= reg_wdata;
        end
        ADDR_ZX_CTRL: begin
          zx_ctrl_reg <= reg_wdata[7:0];
        end
        // Reserved cells are writable; keeping them at default is up to software
        ADDR_RSVD_A: begin
          rsvd_a_reg <= reg_wdata[7:0];
        end
        ADDR_RSVD_B: begin
          rsvd_b_reg <= reg_wdata;
        end
        ADDR_CAL_MODE: begin
          cal_mode_reg <= reg_wdata[7:0];
        end
        ADDR_RSVD_C: begin
          rsvd_c_reg <= reg_wdata[7:0];
        end
        ADDR_RSVD_D: begin
          rsvd_d_reg <= reg_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Source decode: upper bit set means apparent power or current rms
  function automatic emc_source_t src_decode(input logic [1:0] fld, input logic app_rms);
    emc_source_t s;
    s = EMC_SRC_ACTIVE;
    if (fld[1]) begin
      s = app_rms ? EMC_SRC_IRMS : EMC_SRC_APPARENT;
    end else if (fld[0]) begin
      s = EMC_SRC_REACTIVE;
    end
    return s;
  endfunction

  assign po2_next = src_decode(mode_two_reg[FLD_PO2_SRC_LO +: 2], mode_two_reg[BIT_APP_RMS]);
  assign po1_next = src_decode(mode_two_reg[FLD_PO1_SRC_LO +: 2], mode_two_reg[BIT_APP_RMS]);

  // Control outputs are registered copies, so they lag the register by one cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_soft_reset            <= 1'b0;
      zero_cross_filter_off      <= 1'b0;
      integrator_on              <= 1'b0;
      channel_swap               <= 1'b0;
      adc_power_down             <= 1'b0;
      pulse_out_two_off          <= 1'b1;
      pulse_out_one_off          <= 1'b1;
      highpass_off               <= 1'b0;
      pulse_out_two_source       <= EMC_SRC_REACTIVE;
      pulse_out_one_source       <= EMC_SRC_ACTIVE;
      rms_update_on_crossing     <= 1'b0;
      period_or_frequency_choice <= 1'b0;
      waveform_sampling_on       <= 1'b0;
      pulse_out_two_num          <= RST_PO2_NUM;
      pulse_out_two_den          <= RST_PO2_DEN;
      zero_cross_out_en          <= RST_ZX_CTRL;
      calibration_mode_sel       <= RST_CAL_MODE;
      reserved_b_val             <= RST_RSVD_B;
    end else begin
      meas_soft_reset            <= soft_reset_bit_reg;
      zero_cross_filter_off      <= mode_one_reg[BIT_ZX_FILT_OFF];
      integrator_on              <= mode_one_reg[BIT_INTEGRATOR];
      channel_swap               <= mode_one_reg[BIT_SWAP];
      adc_power_down             <= mode_one_reg[BIT_ADC_PD];
      pulse_out_two_off          <= mode_one_reg[BIT_PO2_OFF];
      pulse_out_one_off          <= mode_one_reg[BIT_PO1_OFF];
      highpass_off               <= mode_one_reg[BIT_HPF_OFF];
      pulse_out_two_source       <= po2_next;
      pulse_out_one_source       <= po1_next;
      rms_update_on_crossing     <= mode_two_reg[BIT_RMS_ON_ZX];
      period_or_frequency_choice <= mode_two_reg[BIT_LINE_PERIOD_RESULT];
      waveform_sampling_on       <= mode_two_reg[BIT_WAVE_ON];
      pulse_out_two_num          <= po2_num_reg;
      pulse_out_two_den          <= po2_den_reg;
      zero_cross_out_en          <= zx_ctrl_reg;
      calibration_mode_sel       <= cal_mode_reg;
      reserved_b_val             <= rsvd_b_reg;
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    case (reg_addr)
      ADDR_MODE_ONE: rdata_next = {8'h00, mode_one_reg};
      ADDR_MODE_TWO: rdata_next = {8'h00, mode_two_reg};
      ADDR_PO2_NUM:  rdata_next = po2_num_reg;
      ADDR_PO2_DEN:  rdata_next = po2_den_reg;
      ADDR_ZX_CTRL:  rdata_next = {8'h00, zx_ctrl_reg};
      ADDR_RSVD_A:   rdata_next = {8'h00, rsvd_a_reg};
      ADDR_RSVD_B:   rdata_next = rsvd_b_reg;
      ADDR_CAL_MODE: rdata_next = {8'h00, cal_mode_reg};
      ADDR_RSVD_C:   rdata_next = {8'h00, rsvd_c_reg};
      ADDR_RSVD_D:   rdata_next = {8'h00, rsvd_d_reg};
      default:       rdata_next = 16'h0000;
    endcase
  end

  // Read data holds only in the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 16'h0000;
    end
  end

  a_soft_reset_bit_restores: assert property (@(posedge core_clk) disable iff (!rst_b)
    soft_reset_bit_next |=> (mode_one_reg == RST_MODE_ONE) && (po2_den_reg == RST_PO2_DEN) && (mode_two_reg == RST_MODE_TWO))
    else $error("soft reset did not restore defaults");
  a_soft_reset_bit_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    soft_reset_bit_next |-> ##2 meas_soft_reset)
    else $error("soft reset pulse missing");
  a_zx_filter: assert property (@(posedge core_clk) disable iff (!rst_b)
    zero_cross_filter_off == $past(mode_one_reg[6]))
    else $error("zero-cross filter control wrong");
  a_integ_swap: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_MODE_ONE && !reg_wdata[7]) |-> ##2
      (integrator_on == $past(reg_wdata[5], 2)) && (channel_swap == $past(reg_wdata[4], 2)))
    else $error("integrator or swap not applied");
  a_swap_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(mode_one_reg[4]) |=> channel_swap)
    else $error("channel swap not applied");
  a_adc_pd: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(mode_one_reg[3]) |=> !adc_power_down)
    else $error("adc power-down not released");
  a_out_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    soft_reset_bit_reg |=> pulse_out_one_off && pulse_out_two_off)
    else $error("outputs not disabled after soft reset");
  a_hpf_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    highpass_off == $past(mode_one_reg[0]))
    else $error("high-pass bypass wrong");
  a_src_two: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[7:6] == 2'b00) |=> pulse_out_two_source == EMC_SRC_ACTIVE)
    else $error("second source decode wrong");
  a_src_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[5] && mode_two_reg[3]) |=> pulse_out_one_source == EMC_SRC_IRMS)
    else $error("first source rms choice wrong");
  a_rms_zx: assert property (@(posedge core_clk) disable iff (!rst_b)
    rms_update_on_crossing == $past(mode_two_reg[2]))
    else $error("rms crossing control wrong");
  a_line_period_result: assert property (@(posedge core_clk) disable iff (!rst_b)
    period_or_frequency_choice == $past(mode_two_reg[1]))
    else $error("period/frequency choice wrong");
  a_wave_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    waveform_sampling_on == $past(mode_two_reg[0]))
    else $error("waveform sampling control wrong");
  a_den_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_PO2_DEN && !soft_reset_bit_next) |-> ##2 pulse_out_two_den == $past(reg_wdata, 2))
    else $error("denominator write lost");
  a_cal_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_CAL_MODE) |=> reg_rdata == {8'h00, $past(cal_mode_reg)})
    else $error("calibration read wrong");
  a_zx_ctrl: assert property (@(posedge core_clk) disable iff (!rst_b)
    zero_cross_out_en == $past(zx_ctrl_reg))
    else $error("zero-cross output enable wrong");

  // Every control level tracks its stored bit one edge later, whatever path changed it
  a_integ_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    integrator_on == $past(mode_one_reg[BIT_INTEGRATOR]))
    else $error("integrator control wrong");
  a_swap_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    channel_swap == $past(mode_one_reg[BIT_SWAP]))
    else $error("channel swap control wrong");
  a_pd_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    adc_power_down == $past(mode_one_reg[BIT_ADC_PD]))
    else $error("adc power-down control wrong");
  a_po_two_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    pulse_out_two_off == $past(mode_one_reg[BIT_PO2_OFF]))
    else $error("second output disable wrong");
  a_po_one_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    pulse_out_one_off == $past(mode_one_reg[BIT_PO1_OFF]))
    else $error("first output disable wrong");
  a_mode_one_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_MODE_ONE && !reg_wdata[7]) |=> mode_one_reg == {1'b0, $past(reg_wdata[6:0])})
    else $error("mode one write not stored");
  a_mode_two_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_MODE_TWO) |=> mode_two_reg == $past(reg_wdata[7:0]))
    else $error("mode two write not stored");
  a_src_two_var: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[7:6] == 2'b01) |=> pulse_out_two_source == EMC_SRC_REACTIVE)
    else $error("second source reactive decode wrong");
  a_src_two_va: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[7] && !mode_two_reg[BIT_APP_RMS]) |=> pulse_out_two_source == EMC_SRC_APPARENT)
    else $error("second source apparent choice wrong");
  a_src_two_rms: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[7] && mode_two_reg[BIT_APP_RMS]) |=> pulse_out_two_source == EMC_SRC_IRMS)
    else $error("second source rms choice wrong");
  a_src_one_act: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[5:4] == 2'b00) |=> pulse_out_one_source == EMC_SRC_ACTIVE)
    else $error("first source active decode wrong");
  a_src_one_var: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[5:4] == 2'b01) |=> pulse_out_one_source == EMC_SRC_REACTIVE)
    else $error("first source reactive decode wrong");
  a_src_one_va: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_two_reg[5] && !mode_two_reg[BIT_APP_RMS]) |=> pulse_out_one_source == EMC_SRC_APPARENT)
    else $error("first source apparent choice wrong");
  a_num_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_PO2_NUM) |-> ##2 pulse_out_two_num == $past(reg_wdata, 2))
    else $error("numerator write lost");
  a_num_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_PO2_NUM) |=> reg_rdata == $past(po2_num_reg))
    else $error("numerator read wrong");
  a_den_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_PO2_DEN) |=> reg_rdata == $past(po2_den_reg))
    else $error("denominator read wrong");
  a_zx_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_ZX_CTRL) |=> zx_ctrl_reg == $past(reg_wdata[7:0]))
    else $error("zero-cross control write lost");
  a_zx_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_ZX_CTRL) |=> reg_rdata == {8'h00, $past(zx_ctrl_reg)})
    else $error("zero-cross control read wrong");
  a_cal_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_CAL_MODE) |=> cal_mode_reg == $past(reg_wdata[7:0]))
    else $error("calibration write lost");
  a_cal_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    calibration_mode_sel == $past(cal_mode_reg))
    else $error("calibration mode output wrong");
  a_soft_reset_bit_source: assert property (@(posedge core_clk) disable iff (!rst_b)
    meas_soft_reset |-> $past(soft_reset_bit_next, 2))
    else $error("soft reset pulse without request");
  a_soft_reset_bit_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    soft_reset_bit_next |=> (po2_num_reg == RST_PO2_NUM) && (zx_ctrl_reg == RST_ZX_CTRL) && (cal_mode_reg == RST_CAL_MODE))
    else $error("soft reset left a register set");

  c_soft_reset: cover property (@(posedge core_clk) disable iff (!rst_b) soft_reset_bit_next);
  c_irms_two:   cover property (@(posedge core_clk) disable iff (!rst_b) pulse_out_two_source == EMC_SRC_IRMS);
  c_out_on:     cover property (@(posedge core_clk) disable iff (!rst_b) !pulse_out_one_off && !pulse_out_two_off);
  c_rsvd_read:  cover property (@(posedge core_clk) disable iff (!rst_b) reg_rd && reg_addr == ADDR_RSVD_B);
  c_va_one:     cover property (@(posedge core_clk) disable iff (!rst_b) pulse_out_one_source == EMC_SRC_APPARENT);
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import emc_pkg::*;
  logic                 core_clk  = 1'b0;
  logic                 rst_b     = 1'b0;
  logic [ADDR_W-1:0]    reg_addr  = 7'h00;
  logic [DATA_W-1:0]    reg_wdata = 16'h0000;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 meas_soft_reset;
  logic                 zero_cross_filter_off;
  logic                 integrator_on;
  logic                 channel_swap;
  logic                 adc_power_down;
  logic                 pulse_out_two_off;
  logic                 pulse_out_one_off;
  logic                 highpass_off;
  emc_source_t          pulse_out_two_source;
  emc_source_t          pulse_out_one_source;
  logic                 rms_update_on_crossing;
  logic                 period_or_frequency_choice;
  logic                 waveform_sampling_on;
  logic [15:0]          pulse_out_two_num;
  logic [15:0]          pulse_out_two_den;
  logic [7:0]           zero_cross_out_en;
  logic [7:0]           calibration_mode_sel;
  logic [15:0]          reserved_b_val;
  int                   n_fail      = 0;
  int                   comparisons = 0;
  int                   cycles      = 0;
  logic [6:0]           map_addr [10] = '{ADDR_MODE_ONE, ADDR_MODE_TWO, ADDR_PO2_NUM, ADDR_PO2_DEN, ADDR_ZX_CTRL,
                                          ADDR_RSVD_A, ADDR_RSVD_B, ADDR_CAL_MODE, ADDR_RSVD_C, ADDR_RSVD_D};
  logic [15:0]          map_rst [10]  = '{16'h0006, 16'h0040, 16'h0000, 16'h003F, 16'h0000,
                                          16'h0000, 16'h0300, 16'h0000, 16'h0000, 16'h0000};

  always #25 core_clk = ~core_clk;

  emc_mode_regs u_dut (
    .core_clk                   (core_clk),
    .rst_b                      (rst_b),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .meas_soft_reset            (meas_soft_reset),
    .zero_cross_filter_off      (zero_cross_filter_off),
    .integrator_on              (integrator_on),
    .channel_swap               (channel_swap),
    .adc_power_down             (adc_power_down),
    .pulse_out_two_off          (pulse_out_two_off),
    .pulse_out_one_off          (pulse_out_one_off),
    .highpass_off               (highpass_off),
    .pulse_out_two_source       (pulse_out_two_source),
    .pulse_out_one_source       (pulse_out_one_source),
    .rms_update_on_crossing     (rms_update_on_crossing),
    .period_or_frequency_choice (period_or_frequency_choice),
    .waveform_sampling_on       (waveform_sampling_on),
    .pulse_out_two_num          (pulse_out_two_num),
    .pulse_out_two_den          (pulse_out_two_den),
    .zero_cross_out_en          (zero_cross_out_en),
    .calibration_mode_sel       (calibration_mode_sel),
    .reserved_b_val             (reserved_b_val)
  );

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 600 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Controls lag the register by one edge
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  function automatic logic [15:0] mode_one_out();
    return {9'h000, zero_cross_filter_off, integrator_on, channel_swap, adc_power_down,
            pulse_out_two_off, pulse_out_one_off, highpass_off};
  endfunction

  function automatic logic [1:0] exp_src(input int sel, input int pick_rms);
    if (sel < 2) return 2'(sel);
    return pick_rms ? 2'h3 : 2'h2;
  endfunction

  task automatic check_defaults;
    logic [15:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(map_addr[i], d);
      chk(d, map_rst[i]);
    end
    chk(mode_one_out(), 16'h0006);
    chk({12'h000, pulse_out_two_source, pulse_out_one_source}, 16'h0004);
    chk({13'h0000, rms_update_on_crossing, period_or_frequency_choice, waveform_sampling_on}, 16'h0000);
    chk(pulse_out_two_num, 16'h0000);
    chk(pulse_out_two_den, 16'h003F);
    chk({8'h00, zero_cross_out_en, calibration_mode_sel}, 16'h0000);
    chk(reserved_b_val, 16'h0300);
  endtask

  task automatic test_mode_one;
    logic [15:0] d;
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_MODE_ONE, 16'(1 << i));
      settle();
      chk(mode_one_out(), 16'(1 << i));
      rd(ADDR_MODE_ONE, d);
      chk(d, 16'(1 << i));
    end
  endtask

  task automatic test_mode_two;
    logic [15:0] d;
    logic [15:0] w;
    for (int f = 0; f < 4; f++) begin
      for (int b = 0; b < 2; b++) begin
        // First source takes the opposite field so apparent and rms never mix across outputs
        w = {8'h00, 2'(f), 2'(3 - f), 1'(b), 3'(f * 2 + b)};
        wr(ADDR_MODE_TWO, w);
        settle();
        chk({12'h000, pulse_out_two_source, pulse_out_one_source},
            {12'h000, exp_src(f, b), exp_src(3 - f, b)});
        chk({13'h0000, rms_update_on_crossing, period_or_frequency_choice, waveform_sampling_on},
            {13'h0000, w[2:0]});
        rd(ADDR_MODE_TWO, d);
        chk(d, w);
      end
    end
  endtask

  task automatic test_plain_regs;
    logic [15:0] d;
    wr(ADDR_PO2_NUM, 16'hA5C3);
    wr(ADDR_PO2_DEN, 16'hFFFF);
    wr(ADDR_ZX_CTRL, 16'hFF5A);
    wr(ADDR_CAL_MODE, 16'h12C3);
    settle();
    chk(pulse_out_two_num, 16'hA5C3);
    chk(pulse_out_two_den, 16'hFFFF);
    chk({8'h00, zero_cross_out_en}, 16'h005A);
    chk({8'h00, calibration_mode_sel}, 16'h00C3);
    rd(ADDR_PO2_NUM, d);
    chk(d, 16'hA5C3);
    rd(ADDR_PO2_DEN, d);
    chk(d, 16'hFFFF);
    rd(ADDR_ZX_CTRL, d);
    chk(d, 16'h005A);
    rd(ADDR_CAL_MODE, d);
    chk(d, 16'h00C3);
    rd(7'h0A, d);
    chk(d, 16'h0000);
    rd(7'h7F, d);
    chk(d, 16'h0000);
  endtask

  task automatic test_soft_reset;
    int pulses;
    pulses = 0;
    wr(ADDR_MODE_TWO, 16'h00FF);
    wr(ADDR_MODE_ONE, 16'h00FF);
    repeat (4) begin
      @(posedge core_clk);
      #1 if (meas_soft_reset === 1'b1) pulses++;
    end
    chk(16'(pulses), 16'h0001);
    check_defaults();
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    check_defaults();
    test_mode_one();
    test_mode_two();
    test_plain_regs();
    test_soft_reset();
    end_sim();
  end
endmodule
